/* hw/macsc_regs.svh */
`ifndef MACSC_REGS_SVH
`define MACSC_REGS_SVH
`define MACSC_STATUS_ADDR 8'hcf
`define MACSC_STATUS_RST 8'h00
`define MACSC_BIT_BUSY 0
`define MACSC_BIT_SOFT_OVERFLOW_FLAG 1
`define MACSC_BIT_ZERO 2
`define MACSC_BIT_HARD_OVERFLOW_FLAG 3
`define MACSC_BIT_RDY 4
`define MACSC_BIT_SIGN 5
`define MACSC_BIT_IRQ 6
`define MACSC_BIT_RSVD 7
`define MACSC_EXT_SMAX 8'h7f
`define MACSC_EXT_SMIN 8'h80
`define MACSC_EXT_UMAX 8'hff
`define MACSC_EXT_ZERO 8'h00
`endif

/* hw/macsc_pkg.sv */
package macsc_pkg;
  typedef enum logic [1:0]
  {
    MACSC_IDLE = 2'b00,
    MACSC_CPU  = 2'b01,
    MACSC_DMA  = 2'b10
  } macsc_state_t;
endpackage

/* hw/macsc_flag_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface macsc_flag_if;
  logic [5:0] set_ev;
  logic [5:0] clr_sw;
  logic [5:0] clr_acc;
  logic [5:0] flags;
  modport ctrl
  (
    output set_ev,
    output clr_sw,
    output clr_acc,
    input  flags
  );
  modport bank
  (
    input  set_ev,
    input  clr_sw,
    input  clr_acc,
    output flags
  );
endinterface
`default_nettype wire

/* hw/macsc_flag_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module macsc_flag_bank
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  macsc_flag_if.bank fb
);
  // one sticky bit per flag
  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1)
    begin : g_flag
      logic flag;
      wire  next_flag = fb.set_ev[i] | (flag & ~fb.clr_sw[i] & ~fb.clr_acc[i]); // RL9
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          flag <= 1'b0; // RL16
        else if (ce)
          flag <= next_flag;
      end
      assign fb.flags[i] = flag;
    end
  endgenerate
endmodule
`default_nettype wire

/* hw/macsc_status.sv */
// Overview of operation
// RL1 - software writes zero to reserved bit 7.
// RL2 - irq flag sets on hard overflow, enabled soft overflow, or cpu-mode ready.
// RL3 - signed mode: sign flip flag when result sign differs from expected sign.
// RL4 - result ready flag sets only in cpu mode on operation completion.
// RL5 - signed: hard overflow when extension moves 0x7f<->0x80.
// RL6 - unsigned: hard overflow when extension wraps 0xff to 0x00.
// RL7 - zero flag sets when a completed operation leaves accumulator zero.
// RL8 - soft overflow on carry into bit 31 signed, or into extension unsigned.
// RL9 - flags stay set until software clears them or accumulator clear.
// RL10 - accumulator clear also clears sign, hard overflow, zero, soft overflow.
// RL11 - writing one to busy starts an operation in both modes.
// RL12 - cpu mode: one operation, busy clears when it completes.
// RL13 - dma mode: run all dma operations, busy clears after the last.
// RL14 - clear bit zeroes accumulator and flags except irq and ready; self-clears.
// RL15 - level interrupt request follows the irq flag.
// RL16 - flags update on completion edge and read zero after reset.
`timescale 1ns/1ps
`include "macsc_regs.svh"
`default_nettype none
module macsc_status
(
  // clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       SYS_RST,
  input  wire logic       CE,
  // special function register port
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic [7:0] SFR_WDATA,
  output logic      [7:0] SFR_RDATA,
  // configuration bits
  input  wire logic       DMA_MODE,
  input  wire logic       SIGNED_ARITH_ENABLE,
  input  wire logic       EXPECTED_SIGN_SETTING,
  input  wire logic       SOFT_OVERFLOW_IRQ_ENABLE,
  input  wire logic       ACCUMULATOR_CLEAR_BIT,
  // datapath
  output logic            OP_START,
  input  wire logic       OP_DONE,
  input  wire logic       DMA_ALL_DONE,
  input  wire logic [7:0] EXT_BEFORE,
  input  wire logic [7:0] EXT_AFTER,
  input  wire logic [31:0] ACC_LOW,
  input  wire logic       CARRY_BIT31,
  input  wire logic       CARRY_EXT,
  output logic            ACC_CLEAR,
  output logic            CLEAR_ACK,
  // interrupt
  output logic            MAC_IRQ
);
  localparam int F_SOFT_OVERFLOW_FLAG = `MACSC_BIT_SOFT_OVERFLOW_FLAG - 1;
  localparam int F_ZERO = `MACSC_BIT_ZERO - 1;
  localparam int F_HARD_OVERFLOW_FLAG = `MACSC_BIT_HARD_OVERFLOW_FLAG - 1;
  localparam int F_RDY  = `MACSC_BIT_RDY - 1;
  localparam int F_SIGN = `MACSC_BIT_SIGN - 1;
  localparam int F_IRQ  = `MACSC_BIT_IRQ - 1;

  macsc_pkg::macsc_state_t state;
  macsc_pkg::macsc_state_t next_state;
  logic                    busy;
  logic                    next_busy;
  macsc_flag_if            fb ();

  wire status_wr = SFR_WR & (SFR_ADDR == `MACSC_STATUS_ADDR);
  wire start_req = status_wr & SFR_WDATA[`MACSC_BIT_BUSY] & ~busy; // RL11
  wire op_end    = OP_DONE & (state != macsc_pkg::MACSC_IDLE);
  wire cpu_end   = op_end & (state == macsc_pkg::MACSC_CPU);
  wire dma_end   = DMA_ALL_DONE & (state == macsc_pkg::MACSC_DMA);
  wire sign_bit  = EXT_AFTER[7];

  wire hard_overflow_flag_s = SIGNED_ARITH_ENABLE &
                (((EXT_BEFORE == `MACSC_EXT_SMAX) & (EXT_AFTER == `MACSC_EXT_SMIN)) |
                 ((EXT_BEFORE == `MACSC_EXT_SMIN) & (EXT_AFTER == `MACSC_EXT_SMAX))); // RL5
  wire hard_overflow_flag_u = ~SIGNED_ARITH_ENABLE &
                (EXT_BEFORE == `MACSC_EXT_UMAX) & (EXT_AFTER == `MACSC_EXT_ZERO); // RL6
  wire soft_overflow_flag_ev = SIGNED_ARITH_ENABLE ? CARRY_BIT31 : CARRY_EXT; // RL8
  wire zero_ev = (ACC_LOW == 32'h0000_0000) & (EXT_AFTER == `MACSC_EXT_ZERO); // RL7
  wire sign_ev = SIGNED_ARITH_ENABLE & (sign_bit != EXPECTED_SIGN_SETTING); // RL3
  wire irq_ev  = fb.flags[F_HARD_OVERFLOW_FLAG] |
                 (fb.flags[F_SOFT_OVERFLOW_FLAG] & SOFT_OVERFLOW_IRQ_ENABLE) |
                 fb.flags[F_RDY]; // RL2

  assign fb.set_ev[F_SOFT_OVERFLOW_FLAG] = op_end & soft_overflow_flag_ev;
  assign fb.set_ev[F_ZERO] = op_end & zero_ev;
  assign fb.set_ev[F_HARD_OVERFLOW_FLAG] = op_end & (hard_overflow_flag_s | hard_overflow_flag_u);
  assign fb.set_ev[F_RDY]  = cpu_end; // RL4
  assign fb.set_ev[F_SIGN] = op_end & sign_ev;
  assign fb.set_ev[F_IRQ]  = irq_ev;
  // software writes zero to clear a flag
  genvar k;
  generate
    for (k = 0; k < 6; k = k + 1)
    begin : g_clr
      assign fb.clr_sw[k] = status_wr & ~SFR_WDATA[k + 1]; // RL9
    end
  endgenerate
  assign fb.clr_acc = {1'b0, ACCUMULATOR_CLEAR_BIT, 1'b0, {3{ACCUMULATOR_CLEAR_BIT}}}; // RL10

  macsc_flag_bank u_bank
  (
    .clk (CLK_SYS),
    .rst (SYS_RST),
    .ce  (CE),
    .fb  (fb)
  );

  always_comb
  begin
    next_state = state;
    next_busy  = busy;
    case (state)
      macsc_pkg::MACSC_IDLE:
      begin
        if (start_req)
        begin
          next_busy  = 1'b1;
          next_state = DMA_MODE ? macsc_pkg::MACSC_DMA : macsc_pkg::MACSC_CPU;
        end
      end
      macsc_pkg::MACSC_CPU:
      begin
        if (cpu_end)
        begin
          next_busy  = 1'b0; // RL12
          next_state = macsc_pkg::MACSC_IDLE;
        end
      end
      macsc_pkg::MACSC_DMA:
      begin
        if (dma_end)
        begin
          next_busy  = 1'b0; // RL13
          next_state = macsc_pkg::MACSC_IDLE;
        end
      end
      default:
      begin
        next_busy  = 1'b0;
        next_state = macsc_pkg::MACSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state <= macsc_pkg::MACSC_IDLE;
      busy  <= 1'b0;
    end
    else if (CE)
    begin
      state <= next_state;
      busy  <= next_busy;
    end
  end

  // start pulse and clear command
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      OP_START  <= 1'b0;
      ACC_CLEAR <= 1'b0;
    end
    else if (CE)
    begin
      OP_START  <= start_req;
      ACC_CLEAR <= ACCUMULATOR_CLEAR_BIT; // RL14
    end
  end

  // clear request acknowledged next cycle so the control bit self-clears
  assign CLEAR_ACK = ACC_CLEAR; // RL14
  assign MAC_IRQ   = fb.flags[F_IRQ]; // RL15
  // reserved bit reads zero
  assign SFR_RDATA = {1'b0, fb.flags, busy}; // RL1

  sequence start_seq;
    start_req && !DMA_MODE;
  endsequence
  sequence cpu_done_seq;
    OP_DONE && state == macsc_pkg::MACSC_CPU;
  endsequence
  sequence dma_start_seq;
    start_req && DMA_MODE;
  endsequence
  sequence dma_done_seq;
    DMA_ALL_DONE && state == macsc_pkg::MACSC_DMA;
  endsequence
  sequence uovf_seq;
    op_end && hard_overflow_flag_u;
  endsequence
  sequence soft_overflow_flag_seq;
    op_end && soft_overflow_flag_ev;
  endsequence
  sequence sign_seq;
    op_end && sign_ev;
  endsequence
  sequence hard_overflow_flag_clr_seq;
    status_wr && !SFR_WDATA[3] && !(op_end && (hard_overflow_flag_s || hard_overflow_flag_u));
  endsequence
  sequence irq_clr_seq;
    status_wr && !SFR_WDATA[6] && !irq_ev;
  endsequence

  busy_set_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL11
    (CE and start_seq) |=> busy && state == macsc_pkg::MACSC_CPU)
    else $error("busy not set on start");

  busy_clear_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL12
    (CE and cpu_done_seq) |=> !busy && SFR_RDATA[4])
    else $error("busy or ready wrong after cpu op");

  dma_busy_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL13
    CE && state == macsc_pkg::MACSC_DMA && !DMA_ALL_DONE |=> busy)
    else $error("busy dropped early in dma mode");

  dma_ready_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL4
    state == macsc_pkg::MACSC_DMA && !fb.flags[F_RDY] |=> !fb.flags[F_RDY])
    else $error("ready set in dma mode");

  hard_overflow_flag_set_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL5
    CE && op_end && hard_overflow_flag_s |=> SFR_RDATA[3] ##1 (SFR_RDATA[6] || !CE))
    else $error("hard overflow or irq missing");

  zero_set_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL7
    CE && op_end && zero_ev |=> SFR_RDATA[2])
    else $error("zero flag missing");

  acc_clear_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL10
    CE && ACCUMULATOR_CLEAR_BIT && !op_end |=>
      SFR_RDATA[5:1] == {1'b0, $past(SFR_RDATA[4] && !(status_wr && !SFR_WDATA[4])), 3'b000})
    else $error("clear did not drop flags");

  sticky_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL9
    SFR_RDATA[6] && !status_wr |=> SFR_RDATA[6])
    else $error("irq flag dropped by hardware");

  irq_pin_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL15
    CE && irq_ev |=> MAC_IRQ)
    else $error("irq pin not raised by its source");

  dma_start_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL11
    (CE and dma_start_seq) |=> busy && state == macsc_pkg::MACSC_DMA)
    else $error("busy not set on dma start");

  dma_done_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL13
    (CE and dma_done_seq) |=> !busy && state == macsc_pkg::MACSC_IDLE)
    else $error("busy not cleared after dma");

  cpu_busy_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL12
    CE && state == macsc_pkg::MACSC_CPU && !OP_DONE |=> busy)
    else $error("busy dropped early in cpu mode");

  start_pulse_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL11
    CE && start_req |=> OP_START)
    else $error("start pulse missing");

  start_quiet_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL11
    CE && !start_req |=> !OP_START)
    else $error("start pulse without request");

  uovf_set_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL6
    (CE and uovf_seq) |=> SFR_RDATA[3])
    else $error("unsigned hard overflow missing");

  soft_overflow_flag_set_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL8
    (CE and soft_overflow_flag_seq) |=> SFR_RDATA[1])
    else $error("soft overflow missing");

  sign_set_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL3
    (CE and sign_seq) |=> SFR_RDATA[5])
    else $error("sign flip flag missing");

  sign_gate_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL3
    !SIGNED_ARITH_ENABLE && !SFR_RDATA[5] |=> !SFR_RDATA[5])
    else $error("sign flip flag set in unsigned mode");

  ready_only_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL4
    !cpu_end && !SFR_RDATA[4] |=> !SFR_RDATA[4])
    else $error("ready set without cpu completion");

  hard_overflow_flag_keep_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL9
    SFR_RDATA[3] && !status_wr && !ACCUMULATOR_CLEAR_BIT |=> SFR_RDATA[3])
    else $error("hard overflow dropped by hardware");

  ready_keep_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL14
    SFR_RDATA[4] && !status_wr |=> SFR_RDATA[4])
    else $error("ready dropped without software clear");

  hard_overflow_flag_clear_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL9
    (CE and hard_overflow_flag_clr_seq) |=> !SFR_RDATA[3])
    else $error("hard overflow not cleared by write");

  irq_clear_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL2
    (CE and irq_clr_seq) |=> !MAC_IRQ)
    else $error("irq flag not cleared by write");

  irq_quiet_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL2
    !MAC_IRQ && !irq_ev |=> !MAC_IRQ)
    else $error("irq flag set without source");

  clr_out_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL14
    CE && ACCUMULATOR_CLEAR_BIT |=> ACC_CLEAR && CLEAR_ACK)
    else $error("clear command not raised");

  clr_drop_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL14
    CE && !ACCUMULATOR_CLEAR_BIT |=> !ACC_CLEAR)
    else $error("clear command without request");
endmodule
`default_nettype wire

/* verification/macsc_dp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module macsc_dp_model
(
  // clock
  input  wire logic       clk,
  // start and mode
  input  wire logic       start,
  input  wire logic       dma,
  input  wire logic [3:0] n_ops,
  // completion
  output logic            done,
  output logic            all_done
);
  int k;
  initial
  begin
    done = 1'b0;
    all_done = 1'b0;
    forever
    begin
      @(posedge clk iff start);
      for (k = 0; k < (dma ? int'(n_ops) : 1); k++)
      begin
        repeat (2) @(negedge clk);
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
      end
      if (dma)
      begin
        all_done = 1'b1;
        @(negedge clk);
        all_done = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/mac_status_and_start_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module mac_status_and_start_control_tb_top;
  logic        clk = 0;
  logic        rst = 1;
  logic        wr = 0;
  logic [7:0]  wd = 8'h00;
  logic [7:0]  rd;
  logic        dma = 0;
  logic        sgn = 0;
  logic        sie = 0;
  logic        clr = 0;
  logic        start;
  logic        done;
  logic        all_done;
  logic [7:0]  eb = 8'h00;
  logic [7:0]  ea = 8'h00;
  logic [31:0] acc = 32'h0;
  logic        cx = 0;
  logic        ack;
  logic        irq;
  logic        ce = 1;
  logic [7:0]  addr = 8'hcf;
  logic        esg = 0;
  logic        c31 = 0;
  logic        acl;
  int          n_mismatch = 0;
  int          n_compared = 0;
  always #4 clk = ~clk;
  macsc_status dut_u (.CLK_SYS(clk), .SYS_RST(rst), .CE(ce), .SFR_ADDR(addr),
    .SFR_WR(wr), .SFR_WDATA(wd), .SFR_RDATA(rd), .DMA_MODE(dma),
    .SIGNED_ARITH_ENABLE(sgn), .EXPECTED_SIGN_SETTING(esg),
    .SOFT_OVERFLOW_IRQ_ENABLE(sie), .ACCUMULATOR_CLEAR_BIT(clr), .OP_START(start),
    .OP_DONE(done), .DMA_ALL_DONE(all_done), .EXT_BEFORE(eb), .EXT_AFTER(ea),
    .ACC_LOW(acc), .CARRY_BIT31(c31), .CARRY_EXT(cx), .ACC_CLEAR(acl),
    .CLEAR_ACK(ack), .MAC_IRQ(irq));
  macsc_dp_model dp_u (.clk(clk), .start(start), .dma(dma), .n_ops(4'h3),
    .done(done), .all_done(all_done));
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic wr_st(input logic [7:0] d);
    @(negedge clk);
    wr = 1;
    wd = d;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic run(input logic [7:0] exp);
    int i;
    wr_st(8'h01);
    for (i = 0; i < 40 && rd[0] === 1'b1; i++)
      @(negedge clk);
    repeat (2) @(negedge clk);
    chk(exp, rd);
    chk({7'h0, exp[6]}, {7'h0, irq});
  endtask
  task automatic clr_all;
    wr_st(8'h40);
    wr_st(8'h00);
    chk(8'h00, rd);
  endtask
  task automatic t_zero;
    run(8'h54);
    clr_all();
  endtask
  task automatic t_gate;
    addr = 8'hc0;
    wr_st(8'h01);
    addr = 8'hcf;
    @(negedge clk);
    chk(8'h00, rd);
    ce = 0;
    wr_st(8'h01);
    ce = 1;
    @(negedge clk);
    chk(8'h00, rd);
    chk(8'h00, {7'h0, start});
  endtask
  task automatic t_uovf;
    eb = 8'hff;
    acc = 32'h1;
    cx = 1;
    run(8'h5a);
  endtask
  task automatic t_clr;
    int i;
    @(negedge clk);
    clr = 1;
    for (i = 0; i < 10 && ack !== 1'b1; i++)
      @(negedge clk);
    clr = 0;
    chk(8'h03, {6'h0, acl, ack});
    @(negedge clk);
    chk(8'h50, rd);
    chk(8'h00, {6'h0, acl, ack});
    clr_all();
  endtask
  task automatic t_sgn;
    sgn = 1;
    cx = 0;
    eb = 8'h7f;
    ea = 8'h80;
    run(8'h78);
    clr_all();
    esg = 1;
    c31 = 1;
    eb = 8'h00;
    ea = 8'h01;
    run(8'h72);
    clr_all();
    c31 = 0;
    esg = 0;
    sgn = 0;
  endtask
  task automatic t_dma;
    dma = 1;
    eb = 8'h00;
    ea = 8'h01;
    cx = 1;
    run(8'h02);
    wr_st(8'h00);
    sie = 1;
    run(8'h42);
    clr_all();
  endtask
  task automatic results;
    $display("mismatches=%0d compared=%0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 0;
    chk(8'h00, rd);
    t_zero();
    t_gate();
    t_uovf();
    t_clr();
    t_sgn();
    t_dma();
    results();
  end
  initial
  begin
    #20us;
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
